// ### include/uart_rx_regs.svh
// Purpose: register map, field positions, reset values and sample counts of the receiver
// Assumes: byte addresses on a 32-bit avalon slave, one register per aligned word
// Notes: definitions only
`ifndef UART_RX_REGS_SVH
`define UART_RX_REGS_SVH

// register byte offsets
`define OFS_STATUS_A 4'h0
`define OFS_CTRL_B 4'h4
`define OFS_CTRL_C 4'h8
`define OFS_DATA 4'hc

// status_register_a fields
`define SA_RXC 7
`define SA_FE 4
`define SA_DOR 3
`define SA_PE 2

// control_register_b fields
`define CB_RECEIVE_COMPLETE_IRQ_ENABLE 7
`define CB_RECEIVER_ENABLE 4
`define CB_SZ2 2
`define CB_NINTH 1
`define CB_WMASK 8'h94

// control_register_c fields
`define CC_PEN 5
`define CC_PODD 4
`define CC_STOP2 3
`define CC_SZ_HI 2
`define CC_SZ_LO 1
`define CC_U2X 0

// reset values
`define CTRL_B_RESET 8'h00
`define CTRL_C_RESET 8'h06

// buffered frame word: {overrun, parity err, framing err, data[8:0]}
`define FRAME_W 12
`define FR_DOR 11
`define FR_PE 10
`define FR_FE 9
`define FR_NINTH 8

// oversampling per bit and first voted sample
`define SPB_NORMAL 5'h10
`define SPB_DOUBLE 5'h08
`define VOTE_NORMAL 5'h08
`define VOTE_DOUBLE 5'h04
`define CHAR_SZ_NINE 3'h7

`endif

// ### include/uart_rx_pkg.sv
// Purpose: types shared by the receiver files
// Assumes: uart_rx_regs.svh holds the register map and sample constants
// Notes: receiver state codes are one-hot
package uart_rx_pkg;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_START = 5'h02,
    ST_DATA = 5'h04,
    ST_PARITY = 5'h08,
    ST_STOP = 5'h10
  } rx_state_t;

endpackage

// ### hdl/rx_frame_fifo.sv
// Purpose: small frame buffer of the receiver, oldest entry held in a register
// Assumes: push is ignored when full, pop ignored when empty
// Notes: head entry is always slot 0, so read data come straight from a flip-flop
`timescale 1ns/100ps
`default_nettype none

module rx_frame_fifo #(
  parameter int unsigned WIDTH = 12,
  parameter int unsigned DEPTH = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic flush,
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  input wire logic pop,
  // state
  output logic [WIDTH-1:0] head,
  output logic full,
  output logic empty
);

  localparam int unsigned CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [CW-1:0] cnt;
  } fifo_state_t;

  fifo_state_t q;
  fifo_state_t next_q;
  logic do_pop;
  logic do_push;
  logic [CW-1:0] wr_idx;

  always_comb begin
    next_q = q;
    do_pop = pop && (q.cnt != '0);
    do_push = push && (q.cnt != CW'(DEPTH));
    wr_idx = q.cnt;
    if (do_pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        next_q.mem[i] = q.mem[i + 1];
      end
      next_q.mem[DEPTH-1] = '0;
      wr_idx = q.cnt - CW'(1);
    end
    if (do_push) begin
      next_q.mem[wr_idx] = push_data;
    end
    next_q.cnt = q.cnt + CW'(do_push) - CW'(do_pop);
    if (flush) begin
      next_q.mem = '0;
      next_q.cnt = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign head = q.mem[0];
  assign full = (q.cnt == CW'(DEPTH));
  assign empty = (q.cnt == '0);

endmodule

`default_nettype wire

// ### hdl/uart_rx.sv
// Purpose: uart receive side with start detect, majority vote and a two-frame buffer
// Assumes: SAMPLE_TICK pulses once per oversample period; RXD already synchronous
// Notes: registers reached over avalon-mm, every access answered on its second cycle
//
// Function
// - ninth bit buffered; data read advances
// - rxc flag set while buffer non-empty
// - receiver disable flushes buffer, clears rxc
// - irq level while rxc and enabled
// - error flags buffered with their frame
// - status writes leave error flags
// - error flags never raise interrupts
// - framing error means first stop low
// - only first stop bit checked
// - overrun on start with buffer full and a frame waiting
// - overrun clears on successful transfer
// - parity checked only when enabled
// - parity error zero when checking off
// - disable abandons frame in progress
// - pin override released when disabled
// - sixteen or eight samples per bit
// - falling edge starts, first low sample one
// - vote samples 8-10 or 4-6
// - high majority rejects start as noise
// - resynchronise on every start bit
// - bits decided by centre majority vote
// - first stop moves frame to buffer
//
// Chosen here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
`include "uart_rx_regs.svh"

module uart_rx import uart_rx_pkg::*; #(
  parameter int unsigned FIFO_DEPTH = 2
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // avalon-mm slave
  input wire logic [3:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [3:0] BYTEENABLE,
  input wire logic [31:0] WRITEDATA,
  output logic [31:0] READDATA,
  output logic WAITREQUEST,
  // serial line and baud tick
  input wire logic RXD,
  input wire logic SAMPLE_TICK,
  output logic RXD_OVERRIDE,
  // interrupt request
  output logic RX_IRQ
);

  typedef struct packed {
    rx_state_t fsm;
    logic [4:0] cnt;
    logic [3:0] bitidx;
    logic [1:0] votes;
    logic [8:0] shreg;
    logic par;
    logic prev_line;
    logic pending;
    logic [`FRAME_W-1:0] pend_frame;
    logic dor_pending;
    logic [7:0] ctrl_b;
    logic [7:0] ctrl_c;
    logic ack;
    logic [31:0] rdata;
  } rx_regs_t;

  rx_regs_t q;
  rx_regs_t next_q;

  logic fifo_push;
  logic [`FRAME_W-1:0] fifo_din;
  logic fifo_pop;
  logic [`FRAME_W-1:0] fifo_head;
  logic fifo_full;
  logic fifo_empty;
  logic rx_en;
  logic dbl;
  logic [4:0] spb;
  logic [4:0] vfirst;
  logic [3:0] nbits;
  logic bit_val;
  logic decide;
  logic [`FRAME_W-1:0] done_frame;

  function automatic logic majority(input logic [2:0] v);
    majority = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction

  function automatic logic [3:0] char_bits(input logic [2:0] sz);
    if (sz == `CHAR_SZ_NINE) begin
      char_bits = 4'h9;
    end else begin
      char_bits = 4'h5 + {2'b00, sz[1:0]};
    end
  endfunction

  function automatic logic [31:0] read_mux(input logic [3:0] addr, input rx_regs_t r,
                                           input logic [`FRAME_W-1:0] hd, input logic emp);
    read_mux = '0;
    case (addr[3:2])
      2'h0: begin
        // flag from buffer fill, gone once disabled
        read_mux[`SA_RXC] = ~emp & r.ctrl_b[`CB_RECEIVER_ENABLE];
        read_mux[`SA_FE] = hd[`FR_FE];
        read_mux[`SA_DOR] = hd[`FR_DOR];
        read_mux[`SA_PE] = hd[`FR_PE];
      end
      2'h1: begin
        read_mux[7:0] = r.ctrl_b;
        read_mux[`CB_NINTH] = hd[`FR_NINTH];
      end
      2'h2: begin
        read_mux[7:0] = r.ctrl_c;
      end
      default: begin
        read_mux[7:0] = hd[7:0];
      end
    endcase
  endfunction

  rx_frame_fifo #(
    .WIDTH(`FRAME_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(CLOCK),
    .rst(RST),
    .flush(~rx_en),
    .push(fifo_push),
    .push_data(fifo_din),
    .pop(fifo_pop),
    .head(fifo_head),
    .full(fifo_full),
    .empty(fifo_empty)
  );

  always_comb begin
    next_q = q;
    fifo_push = 1'b0;
    fifo_din = q.pend_frame;
    fifo_pop = 1'b0;
    rx_en = q.ctrl_b[`CB_RECEIVER_ENABLE];
    dbl = q.ctrl_c[`CC_U2X];
    spb = dbl ? `SPB_DOUBLE : `SPB_NORMAL;
    vfirst = dbl ? `VOTE_DOUBLE : `VOTE_NORMAL;
    nbits = char_bits({q.ctrl_b[`CB_SZ2], q.ctrl_c[`CC_SZ_HI], q.ctrl_c[`CC_SZ_LO]});
    bit_val = majority({q.votes, RXD});
    // at count n the line holds sample n+1, so vote ends here
    decide = SAMPLE_TICK && (q.cnt == vfirst + 5'h01);
    done_frame = '0;

    if (!rx_en) begin
      next_q.fsm = ST_IDLE;
      next_q.pending = 1'b0;
      next_q.dor_pending = 1'b0;
      next_q.prev_line = 1'b1;
    end else begin
      // waiting frame moves when room frees
      if (q.pending && !fifo_full) begin
        fifo_push = 1'b1;
        fifo_din = q.pend_frame;
        fifo_din[`FR_DOR] = q.dor_pending;
        next_q.pending = 1'b0;
        next_q.dor_pending = 1'b0;
      end
      if (SAMPLE_TICK && q.fsm != ST_IDLE) begin
        next_q.cnt = (q.cnt == spb) ? 5'h01 : q.cnt + 5'h01;
        next_q.votes = {q.votes[0], RXD};
      end
      case (q.fsm)
        ST_IDLE: begin
          if (SAMPLE_TICK) begin
            next_q.prev_line = RXD;
            // falling edge, first low is sample one
            if (q.prev_line && !RXD) begin
              next_q.fsm = ST_START;
              next_q.cnt = 5'h01;
              next_q.votes = '0;
              next_q.shreg = '0;
              next_q.par = 1'b0;
              next_q.bitidx = '0;
              // third frame lost while buffer full
              if (q.pending && fifo_full) begin
                next_q.dor_pending = 1'b1;
                next_q.pending = 1'b0;
              end
            end
          end
        end
        ST_START: begin
          if (decide) begin
            // noise rejected, watch for next edge
            if (bit_val) begin
              next_q.fsm = ST_IDLE;
              next_q.prev_line = RXD;
            end else begin
              next_q.fsm = ST_DATA;
            end
          end
        end
        ST_DATA: begin
          if (decide) begin
            next_q.shreg[q.bitidx] = bit_val;
            next_q.par = q.par ^ bit_val;
            next_q.bitidx = q.bitidx + 4'h1;
            if (q.bitidx + 4'h1 == nbits) begin
              if (q.ctrl_c[`CC_PEN]) begin
                next_q.fsm = ST_PARITY;
              end else begin
                next_q.par = 1'b0;
                next_q.fsm = ST_STOP;
              end
            end
          end
        end
        ST_PARITY: begin
          if (decide) begin
            next_q.par = q.par ^ bit_val ^ q.ctrl_c[`CC_PODD];
            next_q.fsm = ST_STOP;
          end
        end
        ST_STOP: begin
          if (decide) begin
            done_frame[8:0] = q.shreg;
            done_frame[`FR_PE] = q.par;
            // low first stop is a framing error
            done_frame[`FR_FE] = ~bit_val;
            // later stop bits never looked at
            next_q.fsm = ST_IDLE;
            next_q.prev_line = RXD;
            if (!fifo_full) begin
              fifo_push = 1'b1;
              fifo_din = done_frame;
              fifo_din[`FR_DOR] = q.dor_pending;
              next_q.dor_pending = 1'b0;
            end else begin
              next_q.pending = 1'b1;
              next_q.pend_frame = done_frame;
            end
          end
        end
        default: begin
          next_q.fsm = ST_IDLE;
        end
      endcase
    end

    // bus: first cycle latches read data, second cycle completes
    next_q.ack = (READ || WRITE) && !q.ack;
    if (READ && !q.ack) begin
      next_q.rdata = read_mux(ADDRESS, q, fifo_head, fifo_empty);
    end
    if (WRITE && q.ack && BYTEENABLE[0]) begin
      case (ADDRESS[3:2])
        2'h1: begin
          next_q.ctrl_b = WRITEDATA[7:0] & `CB_WMASK;
        end
        2'h2: begin
          next_q.ctrl_c = WRITEDATA[7:0];
        end
        default: begin
          next_q.ctrl_c = q.ctrl_c;
        end
      endcase
    end
    // data read advances to next frame
    if (READ && q.ack && ADDRESS[3:2] == 2'h3) begin
      fifo_pop = 1'b1;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      q <= '0;
      q.fsm <= ST_IDLE;
      q.prev_line <= 1'b1;
      q.ctrl_b <= `CTRL_B_RESET;
      q.ctrl_c <= `CTRL_C_RESET;
    end else begin
      q <= next_q;
    end
  end

  // combinational handshake keeps a two-cycle answer
  assign WAITREQUEST = (READ || WRITE) && !q.ack;
  assign READDATA = q.rdata;
  assign RXD_OVERRIDE = q.ctrl_b[`CB_RECEIVER_ENABLE];
  // level request, error flags not included
  // errors play no part in the request
  // gated by enable: flush lands one cycle after the write
  assign RX_IRQ = q.ctrl_b[`CB_RECEIVE_COMPLETE_IRQ_ENABLE] && q.ctrl_b[`CB_RECEIVER_ENABLE] && !fifo_empty;

endmodule

`default_nettype wire

// ### test/uart_rx_chk.sv
// Purpose: port assertions of the receiver
// Assumes: master holds a request until waitrequest is low
// Notes: irq may only rise after a tick or a control write
`timescale 1ns/100ps
`default_nettype none
`include "uart_rx_regs.svh"

module uart_rx_chk (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // avalon-mm slave
  input wire logic [3:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [3:0] BYTEENABLE,
  input wire logic [31:0] WRITEDATA,
  input wire logic [31:0] READDATA,
  input wire logic WAITREQUEST,
  // serial side
  input wire logic RXD,
  input wire logic SAMPLE_TICK,
  input wire logic RXD_OVERRIDE,
  input wire logic RX_IRQ
);
  wire logic req = READ || WRITE;
  wire logic wr_b = WRITE && !WAITREQUEST && ADDRESS[3:2] == 2'h1 && BYTEENABLE[0];
  wire logic rd_d = READ && !WAITREQUEST && ADDRESS[3:2] == 2'h3;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  sequence s_open; !req ##1 req; endsequence
  sequence s_wait; req && WAITREQUEST; endsequence
  property p_first; s_open |-> WAITREQUEST; endproperty
  a_first: assert property (p_first) else $error("new request not held");
  property p_ack; s_wait |=> !WAITREQUEST; endproperty
  a_ack: assert property (p_ack) else $error("request not answered in one wait");
  property p_stable; !READ |=> $stable(READDATA); endproperty
  a_stable: assert property (p_stable) else $error("read data moved");
  property p_ovr; wr_b |=> RXD_OVERRIDE == $past(WRITEDATA[`CB_RECEIVER_ENABLE]); endproperty
  a_ovr: assert property (p_ovr) else $error("override not following enable");
  property p_flush; wr_b && !WRITEDATA[`CB_RECEIVER_ENABLE] |=> !RX_IRQ; endproperty
  a_flush: assert property (p_flush) else $error("irq after disable");
  property p_mask; wr_b && !WRITEDATA[`CB_RECEIVE_COMPLETE_IRQ_ENABLE] |=> !RX_IRQ; endproperty
  a_mask: assert property (p_mask) else $error("irq while masked");
  property p_keep; RX_IRQ && !wr_b && !rd_d |=> RX_IRQ; endproperty
  a_keep: assert property (p_keep) else $error("irq dropped unread");
  property p_rise; $rose(RX_IRQ) |-> $past(SAMPLE_TICK) || $past(wr_b); endproperty
  a_rise: assert property (p_rise) else $error("irq rose without cause");
endmodule
`default_nettype wire

// ### test/uart_tx_model.sv
// Purpose: far-end serial transmitter
// Assumes: bits counted in receiver sample ticks
// Notes: line idles high, frame given lsb first
`timescale 1ns/100ps
`default_nettype none

module uart_tx_model (
  // clock and tick
  input wire logic clk,
  input wire logic tick,
  // frame request
  input wire logic [4:0] spb,
  input wire logic go,
  input wire logic [12:0] frame,
  input wire logic [3:0] len,
  // line
  output logic rxd,
  output logic busy
);
  logic [12:0] sh;
  logic [3:0] n;
  logic [4:0] cnt;
  initial busy = 1'b0;
  // released line is pulled to idle
  assign rxd = busy ? sh[0] : 1'b1;
  always @(posedge clk) begin
    if (go) begin
      sh <= frame;
      n <= len;
      cnt <= 5'h0;
      busy <= 1'b1;
    end else if (busy && tick) begin
      cnt <= cnt + 5'h1;
      if (cnt == spb - 5'h1) begin
        cnt <= 5'h0;
        sh <= sh >> 1;
        n <= n - 4'h1;
        busy <= n != 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ### test/uart_rx_tb.sv
// Purpose: self-checking bench of the receiver
// Assumes: tick every second clock
// Notes: frame formats in a table, buffer corners by hand
`timescale 1ns/100ps
`default_nettype none
`include "uart_rx_regs.svh"
`define CHK(nm, e, a) begin checks++; if ((a) !== (e)) begin fail_count++; $display("[FAIL] %s exp %h got %h", nm, e, a); end end

module uart_rx_tb;
  typedef struct {logic [7:0] cc; logic b2; logic [8:0] d; logic stp; logic flip; logic [7:0] st;} row_t;
  logic CLOCK = 1'b0;
  logic RST = 1'b1;
  logic [3:0] ADDRESS = 4'h0;
  logic READ = 1'b0;
  logic WRITE = 1'b0;
  logic [31:0] WRITEDATA = 32'h0;
  logic [31:0] READDATA;
  logic WAITREQUEST;
  logic SAMPLE_TICK = 1'b0;
  logic RXD;
  logic RXD_OVERRIDE;
  logic RX_IRQ;
  logic go = 1'b0;
  logic busy;
  logic [4:0] spb = 5'h10;
  logic [12:0] frame = 13'h1fff;
  logic [3:0] len = 4'h1;
  int fail_count = 0;
  int checks = 0;
  int i;
  int nb;
  row_t rows [8] = '{'{8'h06, 0, 9'h05a, 1, 0, 8'h80}, '{8'h26, 0, 9'h03c, 1, 0, 8'h80},
    '{8'h36, 0, 9'h0c3, 1, 1, 8'h84}, '{8'h06, 0, 9'h0ff, 0, 0, 8'h90}, '{8'h01, 0, 9'h015, 1, 0, 8'h80},
    '{8'h25, 0, 9'h055, 1, 1, 8'h84}, '{8'h06, 1, 9'h1a5, 1, 0, 8'h80}, '{8'h16, 0, 9'h0f0, 1, 1, 8'h80}};

  uart_rx uut (.CLOCK(CLOCK), .RST(RST), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE), .BYTEENABLE(4'hf),
    .WRITEDATA(WRITEDATA), .READDATA(READDATA), .WAITREQUEST(WAITREQUEST), .RXD(RXD),
    .SAMPLE_TICK(SAMPLE_TICK), .RXD_OVERRIDE(RXD_OVERRIDE), .RX_IRQ(RX_IRQ));
  uart_tx_model far (.clk(CLOCK), .tick(SAMPLE_TICK), .spb(spb), .go(go), .frame(frame), .len(len),
    .rxd(RXD), .busy(busy));

  initial begin
    forever #20 CLOCK = ~CLOCK;
  end
  always @(posedge CLOCK) begin
    SAMPLE_TICK <= ~SAMPLE_TICK;
  end

  task automatic complete_run;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] wd, output logic [31:0] rd);
    @(posedge CLOCK);
    ADDRESS <= a;
    WRITE <= w;
    READ <= ~w;
    WRITEDATA <= {24'h0, wd};
    do @(posedge CLOCK); while (WAITREQUEST !== 1'b0);
    rd = READDATA;
    WRITE <= 1'b0;
    READ <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rdchk(input string nm, input logic [3:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 8'h0, r);
    `CHK(nm, e, r)
  endtask
  task automatic tx(input logic [12:0] f, input logic [3:0] n, input logic [4:0] s);
    @(posedge CLOCK);
    frame <= f;
    len <= n;
    spb <= s;
    go <= 1'b1;
    @(posedge CLOCK);
    go <= 1'b0;
  endtask
  task automatic txwait;
    do @(posedge CLOCK); while (busy);
    repeat (2) @(posedge CLOCK);
  endtask
  task automatic send(input logic [8:0] d, input int n, input logic p, input logic pen, input logic stp,
    input logic [4:0] s);
    logic [12:0] f;
    f = 13'h1ffe;
    for (int k = 0; k < n; k++) f[k + 1] = d[k];
    if (pen) f[n + 1] = p;
    f[n + 1 + int'(pen)] = stp;
    tx(f, 4'(n + 2 + int'(pen)), s);
    txwait();
  endtask

  initial begin
    repeat (2) @(posedge CLOCK);
    RST <= 1'b0;
    rdchk("ctrl_b", `OFS_CTRL_B, 32'h0);
    rdchk("ctrl_c", `OFS_CTRL_C, 32'h6);
    rdchk("status", `OFS_STATUS_A, 32'h0);
    `CHK("override", 1'b0, RXD_OVERRIDE)
    for (i = 0; i < 8; i++) begin
      nb = rows[i].b2 ? 9 : 5 + int'(rows[i].cc[2:1]);
      wr(`OFS_CTRL_B, {5'h12, rows[i].b2, 2'h0});
      wr(`OFS_CTRL_C, rows[i].cc);
      send(rows[i].d, nb, ^rows[i].d ^ rows[i].cc[4] ^ rows[i].flip, rows[i].cc[5], rows[i].stp,
        rows[i].cc[0] ? 5'h08 : 5'h10);
      `CHK("irq", 1'b1, RX_IRQ)
      rdchk("status", `OFS_STATUS_A, rows[i].st);
      rdchk("ninth", `OFS_CTRL_B, {5'h12, rows[i].b2, rows[i].d[8], 1'b0});
      rdchk("data", `OFS_DATA, rows[i].d[7:0]);
      rdchk("empty", `OFS_STATUS_A, 32'h0);
    end
    // two buffered, one waiting, then a fourth start
    wr(`OFS_CTRL_C, 8'h06);
    for (i = 1; i < 5; i++) send(9'(8'h11 * i), 8, 1'b0, 1'b0, 1'b1, 5'h10);
    rdchk("status", `OFS_STATUS_A, 32'h80);
    rdchk("data", `OFS_DATA, 32'h11);
    rdchk("status", `OFS_STATUS_A, 32'h80);
    rdchk("data", `OFS_DATA, 32'h22);
    rdchk("status", `OFS_STATUS_A, 32'h88);
    rdchk("data", `OFS_DATA, 32'h44);
    send(9'h055, 8, 1'b0, 1'b0, 1'b1, 5'h10);
    rdchk("status", `OFS_STATUS_A, 32'h80);
    rdchk("data", `OFS_DATA, 32'h55);
    wr(`OFS_CTRL_B, 8'h10);
    send(9'h033, 8, 1'b0, 1'b0, 1'b0, 5'h10);
    `CHK("irq", 1'b0, RX_IRQ)
    wr(`OFS_STATUS_A, 8'h00);
    rdchk("status", `OFS_STATUS_A, 32'h90);
    wr(`OFS_CTRL_B, 8'h90);
    @(posedge CLOCK);
    `CHK("irq", 1'b1, RX_IRQ)
    rdchk("data", `OFS_DATA, 32'h33);
    @(posedge CLOCK);
    `CHK("irq", 1'b0, RX_IRQ)
    // eight low samples lose the vote, nine win it
    tx(13'h0, 4'h1, 5'h08);
    repeat (400) @(posedge CLOCK);
    rdchk("status", `OFS_STATUS_A, 32'h0);
    tx(13'h0, 4'h1, 5'h09);
    repeat (400) @(posedge CLOCK);
    rdchk("status", `OFS_STATUS_A, 32'h80);
    rdchk("data", `OFS_DATA, 32'hff);
    // line stays high after the start bit, so a kept frame would land
    send(9'h066, 8, 1'b0, 1'b0, 1'b1, 5'h10);
    tx(13'h1ffe, 4'hb, 5'h10);
    repeat (120) @(posedge CLOCK);
    wr(`OFS_CTRL_B, 8'h00);
    @(posedge CLOCK);
    `CHK("override", 1'b0, RXD_OVERRIDE)
    `CHK("irq", 1'b0, RX_IRQ)
    rdchk("status", `OFS_STATUS_A, 32'h0);
    wr(`OFS_CTRL_B, 8'h90);
    txwait();
    rdchk("status", `OFS_STATUS_A, 32'h0);
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge CLOCK);
    fail_count++;
    complete_run();
  end
endmodule

bind uart_rx uart_rx_chk chk (.CLOCK(CLOCK), .RST(RST), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE),
  .BYTEENABLE(BYTEENABLE), .WRITEDATA(WRITEDATA), .READDATA(READDATA), .WAITREQUEST(WAITREQUEST),
  .RXD(RXD), .SAMPLE_TICK(SAMPLE_TICK), .RXD_OVERRIDE(RXD_OVERRIDE), .RX_IRQ(RX_IRQ));
`default_nettype wire
